// *** cpust_core.sv ***
// processor registers, flag updates, stacking and interrupt entry/return sequencer
`timescale 1ns/1ps
`include "cpust_map.svh"
module cpust_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // instruction sequencer
  input  wire logic                 opValid,
  input  wire cpust_pkg::cpust_op_t opCode,
  input  wire logic [7:0]           opData,
  input  wire logic                 fetch,
  input  wire logic                 jumpLoad,
  input  wire logic [15:0]          jumpAddr,
  input  wire logic                 callPush,
  input  wire logic                 retPull,
  input  wire logic                 instrEnd,
  // memory bus
  input  wire logic [7:0]           memRdata,
  input  wire logic                 memReady,
  // peripheral interrupt requests: 0 gauge ... 4 timer, 5 external
  input  wire logic [5:0]           irqReq,
  input  wire logic [5:0]           irqEn,
  // processor state
  output logic [7:0]                accReg,
  output logic [7:0]                indexReg,
  output logic [15:0]               stackPointerReg,
  output logic [15:0]               programCounterReg,
  output logic [7:0]                flagRegister,
  // memory access
  output logic [15:0]               memAddr,
  output logic [7:0]                memWdata,
  output logic                      memWr,
  output logic                      memRd,
  // sequencer status
  output logic                      busy,
  output logic                      irqAck,
  output logic [5:0]                irqAckSrc
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_PULL, ST_MUL, ST_RESET_HI, ST_RESET_LO
  } cpust_state_t;

  cpust_state_t state_r;
  logic [5:0]   spLow_r;
  logic [13:0]  pc_r;
  logic [4:0]   ccr_r;
  logic [2:0]   byteCnt_r;
  logic [15:0]  vec_r;
  logic [5:0]   pend_r;
  logic [5:0]   ackSrc_r;
  logic         mulStart;
  logic         mulBusy;
  logic         mulDone;
  logic [15:0]  mulProduct;
  logic [8:0]   sum;
  logic [4:0]   halfSum;
  logic [7:0]   res;
  logic         carryIn;
  logic         isSub;
  logic         isArith;
  logic         irqTake;
  logic         swiTake;

  // highest vector address wins: external first, gauge last
  function automatic logic [5:0] pick_src(input logic [5:0] req);
    logic [5:0] one;
    one = 6'h00;
    for (int i = 0; i < `CPUST_IRQ_N; i++) begin
      if (req[i]) begin
        one = 6'h01 << i;
      end
    end
    return one;
  endfunction : pick_src

  function automatic logic [15:0] src_vec(input logic [5:0] one);
    logic [15:0] v;
    v = `CPUST_VEC_GAUGE;
    case (one)
      6'h20:   v = `CPUST_VEC_EXT;
      6'h10:   v = `CPUST_VEC_TIMER;
      6'h08:   v = `CPUST_VEC_LINK;
      6'h04:   v = `CPUST_VEC_SPI;
      6'h02:   v = `CPUST_VEC_CORE_TIMER_INTERRUPT;
      default: v = `CPUST_VEC_GAUGE;
    endcase
    return v;
  endfunction : src_vec

  cpust_mul uMul (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (mulStart),
    .opA     (accReg),
    .opX     (indexReg),
    .busy    (mulBusy),
    .done    (mulDone),
    .product (mulProduct)
  );

  // alu datapath
  always_comb begin
    isSub   = (opCode == cpust_pkg::CPUST_OP_SUB) || (opCode == cpust_pkg::CPUST_OP_SBC);
    isArith = isSub || (opCode == cpust_pkg::CPUST_OP_ADD) || (opCode == cpust_pkg::CPUST_OP_ADC);
    carryIn = ((opCode == cpust_pkg::CPUST_OP_ADC) || (opCode == cpust_pkg::CPUST_OP_SBC))
              && ccr_r[`CPUST_CCR_C];
    halfSum = {1'b0, accReg[3:0]} + {1'b0, opData[3:0]} + {4'h0, carryIn};
    if (isSub) begin
      sum = {1'b0, accReg} - {1'b0, opData} - {8'h00, carryIn};
    end else begin
      sum = {1'b0, accReg} + {1'b0, opData} + {8'h00, carryIn};
    end
    case (opCode)
      cpust_pkg::CPUST_OP_AND: res = accReg & opData;
      cpust_pkg::CPUST_OP_OR:  res = accReg | opData;
      cpust_pkg::CPUST_OP_EOR: res = accReg ^ opData;
      cpust_pkg::CPUST_OP_LOADA,
      cpust_pkg::CPUST_OP_LOADX: res = opData;
      default: res = sum[7:0];
    endcase
  end

  assign irqTake  = (state_r == ST_IDLE) && instrEnd && !ccr_r[`CPUST_CCR_I]
                    && ((pend_r & irqEn) != 6'h00);
  assign swiTake  = (state_r == ST_IDLE) && opValid && (opCode == cpust_pkg::CPUST_OP_SWI);
  assign mulStart = (state_r == ST_IDLE) && opValid && (opCode == cpust_pkg::CPUST_OP_MUL)
                    && !mulBusy;
  assign busy     = (state_r != ST_IDLE);

  // request latch: a new request wins over the clear of its own acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 6'h00;
    end else begin
      pend_r <= (pend_r & ~ackSrc_r) | irqReq;
    end
  end

  // sequencer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= ST_RESET_HI;
      byteCnt_r <= 3'h0;
      vec_r     <= `CPUST_VEC_RESET;
      ackSrc_r  <= 6'h00;
    end else begin
      ackSrc_r <= 6'h00;
      case (state_r)
        ST_RESET_HI: if (memReady) state_r <= ST_RESET_LO;
        ST_RESET_LO: if (memReady) state_r <= ST_IDLE;
        ST_IDLE: begin
          if (swiTake) begin
            state_r   <= ST_PUSH;
            byteCnt_r <= 3'h0;
            vec_r     <= `CPUST_VEC_SWI;
          end else if (irqTake) begin
            state_r   <= ST_PUSH;
            byteCnt_r <= 3'h0;
          end else if (opValid && opCode == cpust_pkg::CPUST_OP_RTI) begin
            state_r   <= ST_PULL;
            byteCnt_r <= 3'h0;
          end else if (mulStart) begin
            state_r <= ST_MUL;
          end
        end
        ST_PUSH: begin
          if (byteCnt_r == 3'h4) begin
            state_r <= ST_VEC_HI;
            if (vec_r != `CPUST_VEC_SWI) begin
              vec_r    <= src_vec(pick_src(pend_r & irqEn));
              ackSrc_r <= pick_src(pend_r & irqEn);
            end
          end else begin
            byteCnt_r <= byteCnt_r + 3'h1;
          end
        end
        ST_VEC_HI: if (memReady) state_r <= ST_VEC_LO;
        ST_VEC_LO: if (memReady) begin
          state_r <= ST_IDLE;
          vec_r   <= `CPUST_VEC_RESET;
        end
        ST_PULL: if (memReady) begin
          if (byteCnt_r == 3'h4) begin
            state_r <= ST_IDLE;
          end else begin
            byteCnt_r <= byteCnt_r + 3'h1;
          end
        end
        ST_MUL: if (mulDone) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // interrupt acknowledge outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqAck    <= 1'b0;
      irqAckSrc <= 6'h00;
    end else begin
      irqAck    <= (ackSrc_r != 6'h00);
      irqAckSrc <= ackSrc_r;
    end
  end

  // stack pointer low bits; the fixed upper bits never change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spLow_r <= 6'h3F;
    end else if (opValid && state_r == ST_IDLE && opCode == cpust_pkg::CPUST_OP_SP_RESET) begin
      spLow_r <= 6'h3F;
    end else if (state_r == ST_PUSH || (state_r == ST_IDLE && callPush)) begin
      spLow_r <= spLow_r - 6'h01;
    end else if ((state_r == ST_PULL && memReady) || (state_r == ST_IDLE && retPull)) begin
      spLow_r <= spLow_r + 6'h01;
    end
  end

  // program counter, 14 effective bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= 14'h0000;
    end else begin
      case (state_r)
        ST_RESET_HI,
        ST_VEC_HI: if (memReady) pc_r[13:8] <= memRdata[5:0];
        ST_RESET_LO,
        ST_VEC_LO: if (memReady) pc_r[7:0] <= memRdata;
        ST_PULL: if (memReady) begin
          if (byteCnt_r == 3'h3) pc_r[13:8] <= memRdata[5:0];
          if (byteCnt_r == 3'h4) pc_r[7:0]  <= memRdata;
        end
        ST_IDLE: begin
          if (jumpLoad) begin
            pc_r <= jumpAddr[13:0];
          end else if (fetch) begin
            pc_r <= pc_r + 14'h0001;
          end
        end
        default: pc_r <= pc_r;
      endcase
    end
  end

  // working and pointer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accReg   <= 8'h00;
      indexReg <= 8'h00;
    end else if (state_r == ST_MUL && mulDone) begin
      indexReg <= mulProduct[15:8];
      accReg   <= mulProduct[7:0];
    end else if (state_r == ST_PULL && memReady) begin
      if (byteCnt_r == 3'h1) accReg   <= memRdata;
      if (byteCnt_r == 3'h2) indexReg <= memRdata;
    end else if (state_r == ST_IDLE && opValid) begin
      if (opCode == cpust_pkg::CPUST_OP_LOADX) begin
        indexReg <= opData;
      end else if (isArith || opCode == cpust_pkg::CPUST_OP_LOADA
                   || opCode == cpust_pkg::CPUST_OP_AND || opCode == cpust_pkg::CPUST_OP_OR
                   || opCode == cpust_pkg::CPUST_OP_EOR) begin
        accReg <= res;
      end
    end
  end

  // flags H I N Z C
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ccr_r <= 5'(`CPUST_CCR_RESET);
    end else if (state_r == ST_PUSH && byteCnt_r == 3'h4) begin
      ccr_r[`CPUST_CCR_I] <= 1'b1;
    end else if (state_r == ST_PULL && memReady && byteCnt_r == 3'h0) begin
      ccr_r <= memRdata[4:0];
    end else if (state_r == ST_MUL && mulDone) begin
      ccr_r[`CPUST_CCR_H] <= 1'b0;
      ccr_r[`CPUST_CCR_C] <= 1'b0;
    end else if (state_r == ST_IDLE && opValid) begin
      case (opCode)
        cpust_pkg::CPUST_OP_CLI: ccr_r[`CPUST_CCR_I] <= 1'b0;
        cpust_pkg::CPUST_OP_SEI: ccr_r[`CPUST_CCR_I] <= 1'b1;
        cpust_pkg::CPUST_OP_ADD,
        cpust_pkg::CPUST_OP_ADC,
        cpust_pkg::CPUST_OP_SUB,
        cpust_pkg::CPUST_OP_SBC,
        cpust_pkg::CPUST_OP_AND,
        cpust_pkg::CPUST_OP_OR,
        cpust_pkg::CPUST_OP_EOR,
        cpust_pkg::CPUST_OP_LOADA,
        cpust_pkg::CPUST_OP_LOADX: begin
          ccr_r[`CPUST_CCR_N] <= res[7];
          ccr_r[`CPUST_CCR_Z] <= (res == 8'h00);
          if (isArith) ccr_r[`CPUST_CCR_C] <= sum[8];
          if (opCode == cpust_pkg::CPUST_OP_ADD || opCode == cpust_pkg::CPUST_OP_ADC) begin
            ccr_r[`CPUST_CCR_H] <= halfSum[4];
          end
        end
        default: ccr_r <= ccr_r;
      endcase
    end
  end

  // memory access for stacking, pulling and vector fetch; on ready the next byte's address goes out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memAddr  <= `CPUST_VEC_RESET;
      memWdata <= 8'h00;
      memWr    <= 1'b0;
      memRd    <= 1'b0;
    end else begin
      memWr <= 1'b0;
      memRd <= 1'b0;
      if (state_r == ST_PUSH) begin
        memWr    <= 1'b1;
        memAddr  <= {`CPUST_SP_FIXED_HI, spLow_r};
        case (byteCnt_r)
          3'h0:    memWdata <= pc_r[7:0];
          3'h1:    memWdata <= {`CPUST_PC_TOP_ZERO, pc_r[13:8]};
          3'h2:    memWdata <= indexReg;
          3'h3:    memWdata <= accReg;
          default: memWdata <= {`CPUST_CCR_FIXED, ccr_r};
        endcase
      end else if (state_r == ST_PULL) begin
        memRd   <= !(memReady && byteCnt_r == 3'h4);
        memAddr <= {`CPUST_SP_FIXED_HI, spLow_r + (memReady ? 6'h02 : 6'h01)};
      end else if (state_r == ST_VEC_HI || state_r == ST_RESET_HI) begin
        memRd   <= 1'b1;
        memAddr <= memReady ? (vec_r | 16'h0001) : vec_r;
      end else if (state_r == ST_VEC_LO || state_r == ST_RESET_LO) begin
        memRd   <= !memReady;
        memAddr <= vec_r | 16'h0001;
      end
    end
  end

  assign stackPointerReg   = {`CPUST_SP_FIXED_HI, spLow_r};
  assign programCounterReg = {`CPUST_PC_TOP_ZERO, pc_r};
  assign flagRegister      = {`CPUST_CCR_FIXED, ccr_r};
endmodule : cpust_core

// *** cpust_core_assertions.sv ***
// concurrent checks on the ports of the processor-state block
`timescale 1ns/1ps
`include "cpust_map.svh"
module cpust_core_assertions (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // sequencer side
  input wire logic                 opValid,
  input wire cpust_pkg::cpust_op_t opCode,
  input wire logic                 fetch,
  input wire logic                 jumpLoad,
  input wire logic [15:0]          jumpAddr,
  input wire logic                 callPush,
  input wire logic                 retPull,
  input wire logic                 memReady,
  input wire logic [5:0]           irqEn,
  // block outputs
  input wire logic [15:0]          stackPointerReg,
  input wire logic [15:0]          programCounterReg,
  input wire logic [7:0]           flagRegister,
  input wire logic [15:0]          memAddr,
  input wire logic                 memWr,
  input wire logic                 memRd,
  input wire logic                 busy,
  input wire logic                 irqAck,
  input wire logic [5:0]           irqAckSrc
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_sp_fixed;
    stackPointerReg[15:6] == `CPUST_SP_FIXED_HI && (!memWr || memAddr[15:6] == `CPUST_SP_FIXED_HI);
  endproperty
  a_sp_fixed: assert property (p_sp_fixed) else $error("stack outside its page");
  property p_fixed_bits;
    programCounterReg[15:14] == `CPUST_PC_TOP_ZERO && flagRegister[7:5] == `CPUST_CCR_FIXED;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits moved");
  property p_fetch;
    fetch && !jumpLoad && !busy |=> programCounterReg[13:0] == $past(programCounterReg[13:0]) + 14'h1;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not advance pc");
  property p_jump;
    jumpLoad && !busy |=> programCounterReg == {2'h0, $past(jumpAddr[13:0])};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  property p_push;
    callPush && !busy |=> stackPointerReg[5:0] == $past(stackPointerReg[5:0]) - 6'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not decrement");
  property p_pull;
    retPull && !busy |=> stackPointerReg[5:0] == $past(stackPointerReg[5:0]) + 6'h01;
  endproperty
  a_pull: assert property (p_pull) else $error("pull did not increment");
  property p_sp_reset;
    opValid && !busy && opCode == cpust_pkg::CPUST_OP_SP_RESET |=> stackPointerReg == `CPUST_SP_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack reset missed");
  property p_entry_five;
    irqAck && |irqAckSrc |-> stackPointerReg[5:0] == $past(stackPointerReg[5:0], 6) - 6'h05;
  endproperty
  a_entry_five: assert property (p_entry_five) else $error("entry not five bytes");
  property p_entry_vec;
    irqAck |-> flagRegister[`CPUST_CCR_I] && memRd && memAddr[15:4] == 12'h3FF;
  endproperty
  a_entry_vec: assert property (p_entry_vec) else $error("entry without mask or vector");
  property p_ack_src;
    irqAck && |irqAckSrc |-> $onehot(irqAckSrc & irqEn);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("serviced source not enabled");
  property p_mask_clear;
    $fell(flagRegister[`CPUST_CCR_I]) |-> busy || $past(busy) || $past(opValid && opCode == cpust_pkg::CPUST_OP_CLI);
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask cleared by hardware");
  property p_rd_hold;
    memRd && !memReady |=> memRd && $stable(memAddr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped before ready");
endmodule : cpust_core_assertions

bind cpust_core cpust_core_assertions chk_u (.clk(clk), .rst_b(rst_b), .opValid(opValid),
  .opCode(opCode), .fetch(fetch), .jumpLoad(jumpLoad), .jumpAddr(jumpAddr), .callPush(callPush),
  .retPull(retPull), .memReady(memReady), .irqEn(irqEn), .stackPointerReg(stackPointerReg),
  .programCounterReg(programCounterReg), .flagRegister(flagRegister), .memAddr(memAddr),
  .memWr(memWr), .memRd(memRd), .busy(busy), .irqAck(irqAck), .irqAckSrc(irqAckSrc));

// *** cpust_core_bench.sv ***
// self-checking bench for the processor-state block
`timescale 1ns/1ps
`include "cpust_map.svh"
module cpust_core_bench;
  localparam logic [15:0] RST_TGT = 16'h1234;
  localparam logic [15:0] SWI_TGT = 16'h0500;
  localparam logic [15:0] SPI_TGT = 16'h0240;
  localparam logic [15:0] GAU_TGT = 16'h0300;
  logic                 clk, rst_b, opValid, fetch, jumpLoad, callPush, retPull, instrEnd;
  logic                 memReady, memWr, memRd, busy, irqAck;
  cpust_pkg::cpust_op_t opCode;
  logic [7:0]           opData, memRdata, accReg, indexReg, flagRegister, memWdata;
  logic [15:0]          jumpAddr, stackPointerReg, programCounterReg, memAddr;
  logic [5:0]           irqReq, irqEn, irqAckSrc, ackSrc;
  logic [3:0]           slowCycles;
  int                   failures, n_tests, ackCnt;
  logic [15:0]          wrAddr[$];
  logic [7:0]           wrData[$];

  cpust_core dut_u (.clk(clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
    .opData(opData), .fetch(fetch), .jumpLoad(jumpLoad), .jumpAddr(jumpAddr),
    .callPush(callPush), .retPull(retPull), .instrEnd(instrEnd), .memRdata(memRdata),
    .memReady(memReady), .irqReq(irqReq), .irqEn(irqEn), .accReg(accReg), .indexReg(indexReg),
    .stackPointerReg(stackPointerReg), .programCounterReg(programCounterReg),
    .flagRegister(flagRegister), .memAddr(memAddr), .memWdata(memWdata), .memWr(memWr),
    .memRd(memRd), .busy(busy), .irqAck(irqAck), .irqAckSrc(irqAckSrc));
  cpust_mem_model #(.RST_TGT(RST_TGT), .SWI_TGT(SWI_TGT), .SPI_TGT(SPI_TGT), .GAU_TGT(GAU_TGT))
    mem_u (.clk(clk), .rst_b(rst_b), .memAddr(memAddr), .memWdata(memWdata), .memWr(memWr),
    .memRd(memRd), .slowCycles(slowCycles), .memRdata(memRdata), .memReady(memReady));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (memWr) begin
      wrAddr.push_back(memAddr);
      wrData.push_back(memWdata);
    end
    if (irqAck) begin
      ackSrc <= irqAckSrc;
      ackCnt++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic do_op(input cpust_pkg::cpust_op_t op, input logic [7:0] d);
    @(posedge clk);
    opValid <= 1'b1;
    opCode  <= op;
    opData  <= d;
    @(posedge clk);
    opValid <= 1'b0;
  endtask : do_op
  task automatic wait_idle();
    int k;
    k = 0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk(k < 300, 1'b1, "busy never fell");
  endtask : wait_idle
  task automatic end_pulse();
    @(posedge clk);
    instrEnd <= 1'b1;
    @(posedge clk);
    instrEnd <= 1'b0;
  endtask : end_pulse

  task automatic t_reset();
    wait_idle();
    chk(stackPointerReg, `CPUST_SP_RESET, "sp at reset");
    chk(flagRegister, `CPUST_CCR_RESET, "flags at reset");
    chk({accReg, indexReg}, 16'h0000, "acc and index at reset");
    chk(programCounterReg, RST_TGT, "reset vector");
    $display("test reset done");
  endtask : t_reset
  task automatic t_alu();
    cpust_pkg::cpust_op_t ops[10] = '{cpust_pkg::CPUST_OP_LOADA, cpust_pkg::CPUST_OP_ADD,
      cpust_pkg::CPUST_OP_ADD, cpust_pkg::CPUST_OP_ADC, cpust_pkg::CPUST_OP_SUB,
      cpust_pkg::CPUST_OP_SBC, cpust_pkg::CPUST_OP_AND, cpust_pkg::CPUST_OP_EOR,
      cpust_pkg::CPUST_OP_OR, cpust_pkg::CPUST_OP_LOADX};
    logic [7:0] dat[10]  = '{8'h0F, 8'h01, 8'hF0, 8'h01, 8'h03, 8'h00, 8'h0F, 8'h0E, 8'h80, 8'h5A};
    logic [7:0] expA[10] = '{8'h0F, 8'h10, 8'h00, 8'h02, 8'hFF, 8'hFE, 8'h0E, 8'h00, 8'h80, 8'h80};
    logic [7:0] flg[10]  = '{8'h00, 8'h10, 8'h03, 8'h00, 8'h05, 8'h04, 8'h00, 8'h02, 8'h04, 8'h00};
    logic [7:0] msk[10]  = '{8'h00, 8'h17, 8'h17, 8'h17, 8'h07, 8'h07, 8'h06, 8'h06, 8'h06, 8'h00};
    for (int i = 0; i <= 10; i++) begin
      @(posedge clk);
      opValid <= (i < 10);
      if (i < 10) begin
        opCode <= ops[i];
        opData <= dat[i];
      end
      @(negedge clk);
      if (i > 0) begin
        chk(accReg, expA[i-1], "acc result");
        chk(flagRegister & msk[i-1], flg[i-1], "flags");
      end
    end
    chk(indexReg, 8'h5A, "index load");
    $display("test alu done");
  endtask : t_alu
  task automatic t_mul();
    do_op(cpust_pkg::CPUST_OP_LOADA, 8'hC8);
    do_op(cpust_pkg::CPUST_OP_LOADX, 8'h0B);
    do_op(cpust_pkg::CPUST_OP_MUL, 8'h00);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk(busy, 1'b1, "mul still running");
    @(negedge clk);
    chk({indexReg, accReg}, 16'h0898, "product");
    chk(flagRegister & 8'h11, 8'h00, "mul clears half and carry");
    $display("test mul done");
  endtask : t_mul
  task automatic t_stack();
    do_op(cpust_pkg::CPUST_OP_SP_RESET, 8'h00);
    callPush <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(stackPointerReg, 16'h00FE, "one push");
    repeat (63) @(posedge clk);
    callPush <= 1'b0;
    @(negedge clk);
    chk(stackPointerReg, 16'h00FF, "wrap after 64");
    @(posedge clk);
    retPull <= 1'b1;
    @(posedge clk);
    retPull <= 1'b0;
    @(negedge clk);
    chk(stackPointerReg, 16'h00C0, "pull wraps to page bottom");
    do_op(cpust_pkg::CPUST_OP_SP_RESET, 8'h00);
    @(negedge clk);
    chk(stackPointerReg, 16'h00FF, "stack reset");
    $display("test stack done");
  endtask : t_stack
  task automatic t_swi();
    do_op(cpust_pkg::CPUST_OP_SWI, 8'h00);
    wait_idle();
    chk(programCounterReg, SWI_TGT, "software vector while masked");
    chk(stackPointerReg, 16'h00FA, "software entry stack");
    $display("test swi done");
  endtask : t_swi
  task automatic t_irq();
    logic [7:0] stk[5] = '{8'h25, 8'h01, 8'h5A, 8'h00, 8'hE2};
    do_op(cpust_pkg::CPUST_OP_SP_RESET, 8'h00);
    do_op(cpust_pkg::CPUST_OP_LOADX, 8'h5A);
    do_op(cpust_pkg::CPUST_OP_LOADA, 8'h00);
    do_op(cpust_pkg::CPUST_OP_ADD, 8'h00);
    jumpLoad   <= 1'b1;
    fetch      <= 1'b1;
    jumpAddr   <= 16'hC123;
    irqEn      <= 6'h1F;
    slowCycles <= 4'h2;
    irqReq     <= 6'h25;
    @(posedge clk);
    jumpLoad <= 1'b0;
    irqReq   <= 6'h00;
    repeat (2) @(posedge clk);
    fetch <= 1'b0;
    @(negedge clk);
    chk(programCounterReg, 16'h0125, "jump wins then fetches");
    end_pulse();
    repeat (10) @(posedge clk);
    chk(ackCnt, 0, "masked request taken");
    do_op(cpust_pkg::CPUST_OP_CLI, 8'h00);
    wrAddr.delete();
    wrData.delete();
    repeat (8) @(posedge clk);
    chk(ackCnt, 0, "taken before instruction end");
    end_pulse();
    wait_idle();
    chk({ackCnt[9:0], ackSrc}, {10'd1, 6'h04}, "highest enabled source");
    chk(programCounterReg, SPI_TGT, "spi vector");
    chk(flagRegister[`CPUST_CCR_I], 1'b1, "mask set on entry");
    chk(wrAddr.size(), 5, "entry pushes");
    for (int i = 0; i < 5; i++) begin
      chk(wrAddr[i], 16'h00FF - i, "push address");
      chk(wrData[i], stk[i], "push data");
    end
    do_op(cpust_pkg::CPUST_OP_RTI, 8'h00);
    wait_idle();
    chk({accReg, indexReg}, 16'h005A, "registers restored");
    chk(flagRegister, 8'hE2, "mask restored clear");
    chk(programCounterReg, 16'h0125, "resume address");
    chk(stackPointerReg, 16'h00FF, "stack restored");
    end_pulse();
    wait_idle();
    chk({ackCnt[9:0], ackSrc}, {10'd2, 6'h01}, "latched lower source next");
    chk(programCounterReg, GAU_TGT, "gauge vector");
    $display("test irq done");
  endtask : t_irq

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    {rst_b, opValid, fetch, jumpLoad, callPush, retPull, instrEnd} = 7'h00;
    opCode = cpust_pkg::CPUST_OP_NONE;
    {opData, jumpAddr} = '0;
    {irqReq, irqEn, slowCycles} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_alu();
    t_mul();
    t_stack();
    t_swi();
    t_irq();
    finish_test();
  end
endmodule : cpust_core_bench

// *** cpust_map.svh ***
// register layout, reset values, vectors and cycle counts of the processor-state block
`ifndef CPUST_MAP_SVH
`define CPUST_MAP_SVH
`define CPUST_SP_RESET      16'h00FF
`define CPUST_SP_FIXED_HI   10'h003
`define CPUST_SP_LOW_W      6
`define CPUST_PC_TOP_ZERO   2'h0
`define CPUST_CCR_FIXED     3'h7
`define CPUST_CCR_H         4
`define CPUST_CCR_I         3
`define CPUST_CCR_N         2
`define CPUST_CCR_Z         1
`define CPUST_CCR_C         0
`define CPUST_CCR_RESET     8'hE8
`define CPUST_VEC_RESET     16'h3FFE
`define CPUST_VEC_SWI       16'h3FFC
`define CPUST_VEC_EXT       16'h3FFA
`define CPUST_VEC_TIMER     16'h3FF8
`define CPUST_VEC_LINK      16'h3FF6
`define CPUST_VEC_SPI       16'h3FF4
`define CPUST_VEC_CORE_TIMER_INTERRUPT    16'h3FF2
`define CPUST_VEC_GAUGE     16'h3FF0
`define CPUST_MUL_CYCLES    4'hB
`define CPUST_IRQ_N         6
`endif

// *** cpust_mem_model.sv ***
// program memory with vector table, optional wait states
`timescale 1ns/1ps
`include "cpust_map.svh"
module cpust_mem_model #(
  parameter logic [15:0] RST_TGT = 16'h0000,
  parameter logic [15:0] SWI_TGT = 16'h0000,
  parameter logic [15:0] SPI_TGT = 16'h0000,
  parameter logic [15:0] GAU_TGT = 16'h0000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // memory bus
  input  wire logic [15:0] memAddr,
  input  wire logic [7:0]  memWdata,
  input  wire logic        memWr,
  input  wire logic        memRd,
  input  wire logic [3:0]  slowCycles,
  output logic [7:0]       memRdata,
  output logic             memReady
);
  logic [7:0] mem [0:16383];
  logic [3:0] waitCnt_r;
  logic [7:0] lastData_r;
  // high byte at the even address
  initial begin
    {mem[`CPUST_VEC_RESET], mem[`CPUST_VEC_RESET + 1]}   = RST_TGT;
    {mem[`CPUST_VEC_SWI], mem[`CPUST_VEC_SWI + 1]}       = SWI_TGT;
    {mem[`CPUST_VEC_SPI], mem[`CPUST_VEC_SPI + 1]}       = SPI_TGT;
    {mem[`CPUST_VEC_GAUGE], mem[`CPUST_VEC_GAUGE + 1]}   = GAU_TGT;
  end
  always @(posedge clk) begin
    if (memWr) mem[memAddr[13:0]] <= memWdata;
  end
  assign memReady = memRd && (waitCnt_r == slowCycles);
  // no stale data while not ready
  assign memRdata = memReady ? mem[memAddr[13:0]] : ~lastData_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r  <= 4'h0;
      lastData_r <= 8'h00;
    end else if (memReady) begin
      waitCnt_r  <= 4'h0;
      lastData_r <= memRdata;
    end else if (memRd) begin
      waitCnt_r <= waitCnt_r + 4'h1;
    end
  end
endmodule : cpust_mem_model

// *** cpust_mul.sv ***
// add-and-shift multiplier for the working and pointer registers
`timescale 1ns/1ps
`include "cpust_map.svh"
module cpust_mul (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // request
  input  wire logic        start,
  input  wire logic [7:0]  opA,
  input  wire logic [7:0]  opX,
  // result
  output logic             busy,
  output logic             done,
  output logic [15:0]      product
);
  logic [3:0]  cnt_r;
  logic [15:0] acc_r;
  logic [7:0]  mcand_r;
  logic [7:0]  mplier_r;

  // one add-shift step per cycle, 8 steps plus setup and finish
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r    <= 4'h0;
      acc_r    <= 16'h0000;
      mcand_r  <= 8'h00;
      mplier_r <= 8'h00;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && cnt_r == 4'h0) begin
        cnt_r    <= `CPUST_MUL_CYCLES - 4'h1;
        acc_r    <= 16'h0000;
        mcand_r  <= opA;
        mplier_r <= opX;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r > 4'h2) begin
          acc_r    <= (acc_r << 1) + (mplier_r[7] ? {8'h00, mcand_r} : 16'h0000);
          mplier_r <= {mplier_r[6:0], 1'b0};
        end
        if (cnt_r == 4'h1) begin
          done <= 1'b1;
        end
      end
    end
  end

  assign busy    = (cnt_r != 4'h0);
  assign product = acc_r;
endmodule : cpust_mul

// *** cpust_pkg.sv ***
// types of the processor-state block
package cpust_pkg;
  typedef enum logic [3:0] {
    CPUST_OP_NONE, CPUST_OP_LOADA, CPUST_OP_LOADX, CPUST_OP_ADD, CPUST_OP_ADC,
    CPUST_OP_SUB, CPUST_OP_SBC, CPUST_OP_AND, CPUST_OP_OR, CPUST_OP_EOR,
    CPUST_OP_MUL, CPUST_OP_SP_RESET, CPUST_OP_CLI, CPUST_OP_SEI,
    CPUST_OP_SWI, CPUST_OP_RTI
  } cpust_op_t;
  typedef enum logic [1:0] {
    CPUST_PC_INC, CPUST_PC_HOLD, CPUST_PC_LOAD
  } cpust_pcop_t;
endpackage : cpust_pkg
